//--- src/fcs_sequencer.sv
// Erase, unsecure and backdoor key command sequencer of the flash controller.
`timescale 1ns/100ps
`include "fcs_cfg.svh"
// How it works
// - Code 08 erases and verifies everything; index other than 000 gives access error.
// - Erase-all or unsecure releases security only when verify finds all erased.
// - Erase-all and unsecure flag protection violation if any region is protected.
// - Code 09 erases and verifies the block named by address bits 22..16.
// - Block erase needs phrase-aligned program or word-aligned data address.
// - Block and sector erase give access error on an invalid block.
// - Block erase flags protection violation if any part is protected.
// - Code 0A erases and verifies the program sector holding the address.
// - Sector erase gives access error when address bits 2..0 are not zero.
// - Sector erase flags protection violation on a protected sector.
// - Verify sets verify error on any error, uncorrectable on fatal ones.
// - Code 0B erases and verifies everything; index other than 000 gives access error.
// - Failed unsecure verify sets verify error and leaves security unchanged.
// - Clearing complete launches; complete sets again only when all is finished.
// - Code 0C takes four keys; index other than 100 gives access error.
// - Key verify needs key enable equal to 10, else access error.
// - Keys are compared in order from the key location; full match unsecures.
// - After a key mismatch every later key verify fails until reset.
// - A command not allowed in the current mode gives access error.
module fcs_sequencer
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Software side
  input wire logic paramIdxWrEn,
  input wire logic [2:0] paramIdxWrData,
  input wire logic paramWrEn,
  input wire logic [15:0] paramWrData,
  input wire logic cmdLaunch,
  input wire logic errFlagClear,
  output logic [2:0] cmdParamIndex,
  output fcs_flags_s flashStatus,
  // Configuration and mode
  input wire logic secCfgSecure,
  input wire logic [1:0] backdoorKeyEnable,
  input wire logic cmdModeAllowed,
  // Flash map and protection, answered for the address on arrayReq.addr
  input wire logic protAnyRegion,
  input wire logic blockValid,
  input wire logic blockIsData,
  input wire logic targetProtected,
  // Flash array
  output fcs_array_req_s arrayReq,
  input wire logic arrayDone,
  input wire logic verifyFail,
  input wire logic verifyUncorrectable,
  // Stored key reads
  output logic keyRdReq,
  output logic [22:0] keyRdAddr,
  input wire logic keyRdValid,
  input wire logic [15:0] keyRdData,
  // Security state
  output logic secured
);

  fcs_state_s s_ff;
  fcs_state_s nxt_s;
  fcs_words_t params;
  logic launchOk;
  logic [7:0] newCmd;
  logic isWhole;

  // ==========================================================================
  // Parameter words
  fcs_param_bank uBank (
    .core_clk(core_clk),
    .reset(reset),
    .wrEn(paramWrEn && s_ff.flags.cmdComplete),
    .wrIdx(s_ff.idx),
    .wrData(paramWrData),
    .words(params)
  );

  // A launch is ignored while an access error or protection violation is still flagged.
  assign launchOk = cmdLaunch && s_ff.flags.cmdComplete && !s_ff.flags.accessError
                    && !s_ff.flags.protViolation && (s_ff.st == FCS_IDLE);
  assign newCmd = params[0][`FCS_CMD_HI:`FCS_CMD_LO];
  assign isWhole = (s_ff.cmd == `FCS_CMD_ERASE_ALL) || (s_ff.cmd == `FCS_CMD_UNSECURE);

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.arr.req = 1'b0;
    nxt_s.keyReq = 1'b0;
    if (!s_ff.cfgLoaded) begin
      nxt_s.secured = secCfgSecure;
      nxt_s.cfgLoaded = 1'b1;
    end
    if (paramIdxWrEn && s_ff.flags.cmdComplete) begin
      nxt_s.idx = paramIdxWrData;
    end
    if (errFlagClear) begin
      nxt_s.flags.accessError = 1'b0;
      nxt_s.flags.protViolation = 1'b0;
    end
    unique case (s_ff.st)
      FCS_IDLE: begin
        if (launchOk) begin
          nxt_s.flags.cmdComplete = 1'b0;
          nxt_s.flags.verifyError = 1'b0;
          nxt_s.flags.uncorrectable = 1'b0;
          nxt_s.cmd = newCmd;
          nxt_s.arr.addr = {params[0][`FCS_BLK_HI:0], params[1]};
          nxt_s.st = FCS_FIN;
          if (!cmdModeAllowed) begin
            nxt_s.flags.accessError = 1'b1;
          end else if ((newCmd == `FCS_CMD_ERASE_ALL) || (newCmd == `FCS_CMD_UNSECURE)) begin
            if (s_ff.idx != `FCS_IDX_NONE) begin
              nxt_s.flags.accessError = 1'b1;
            end else if (protAnyRegion) begin
              nxt_s.flags.protViolation = 1'b1;
            end else begin
              nxt_s.arr.req = 1'b1;
              nxt_s.arr.verify = 1'b0;
              nxt_s.arr.scope = FCS_SCOPE_ALL;
              nxt_s.st = FCS_ERASE;
            end
          end else if ((newCmd == `FCS_CMD_ERASE_BLK) || (newCmd == `FCS_CMD_ERASE_SEC)) begin
            if (s_ff.idx != `FCS_IDX_ADDR) begin
              nxt_s.flags.accessError = 1'b1;
            end else begin
              nxt_s.st = FCS_CHECK;
            end
          end else if (newCmd == `FCS_CMD_KEY_VERIFY) begin
            if ((s_ff.idx != `FCS_IDX_KEYS) || (backdoorKeyEnable != `FCS_BACKDOOR_KEY_ENABLE_ON)
                || s_ff.keyLock) begin
              nxt_s.flags.accessError = 1'b1;
            end else begin
              nxt_s.keyReq = 1'b1;
              nxt_s.keyIdx = 2'h0;
              nxt_s.keyAddr = `FCS_KEY_BASE;
              nxt_s.st = FCS_KEY;
            end
          end else begin
            nxt_s.flags.accessError = 1'b1;
          end
        end
      end
      FCS_CHECK: begin
        nxt_s.st = FCS_FIN;
        if (!blockValid || ((s_ff.cmd == `FCS_CMD_ERASE_SEC) && blockIsData)) begin
          nxt_s.flags.accessError = 1'b1;
        end else if ((s_ff.cmd == `FCS_CMD_ERASE_BLK) && blockIsData && s_ff.arr.addr[0]) begin
          nxt_s.flags.accessError = 1'b1;
        end else if (!blockIsData && (s_ff.arr.addr[2:0] != 3'h0)) begin
          nxt_s.flags.accessError = 1'b1;
        end else if (targetProtected) begin
          nxt_s.flags.protViolation = 1'b1;
        end else begin
          nxt_s.arr.req = 1'b1;
          nxt_s.arr.verify = 1'b0;
          nxt_s.arr.scope = (s_ff.cmd == `FCS_CMD_ERASE_BLK) ? FCS_SCOPE_BLOCK
                                                              : FCS_SCOPE_SECTOR;
          nxt_s.st = FCS_ERASE;
        end
      end
      FCS_ERASE: begin
        if (arrayDone) begin
          nxt_s.arr.req = 1'b1;
          nxt_s.arr.verify = 1'b1;
          nxt_s.st = FCS_VERIFY;
        end
      end
      FCS_VERIFY: begin
        if (arrayDone) begin
          nxt_s.flags.verifyError = verifyFail;
          nxt_s.flags.uncorrectable = verifyUncorrectable;
          if (isWhole && !verifyFail) begin
            nxt_s.secured = 1'b0;
          end
          nxt_s.st = FCS_FIN;
        end
      end
      FCS_KEY: begin
        if (keyRdValid) begin
          if (keyRdData != params[3'(s_ff.keyIdx) + 3'h1]) begin
            nxt_s.keyLock = 1'b1;
            nxt_s.flags.accessError = 1'b1;
            nxt_s.st = FCS_FIN;
          end else if (s_ff.keyIdx == `FCS_KEY_LAST) begin
            nxt_s.secured = 1'b0;
            nxt_s.st = FCS_FIN;
          end else begin
            nxt_s.keyIdx = s_ff.keyIdx + 2'h1;
            nxt_s.keyAddr = s_ff.keyAddr + 23'h2;
            nxt_s.keyReq = 1'b1;
          end
        end
      end
      FCS_FIN: begin
        nxt_s.flags.cmdComplete = 1'b1;
        nxt_s.st = FCS_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.st <= FCS_IDLE;
      s_ff.flags.cmdComplete <= 1'b1;
      s_ff.secured <= `FCS_RST_SECURED;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign cmdParamIndex = s_ff.idx;
  assign flashStatus = s_ff.flags;
  assign arrayReq = s_ff.arr;
  assign keyRdReq = s_ff.keyReq;
  assign keyRdAddr = s_ff.keyAddr;
  assign secured = s_ff.secured;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence sLaunchWhole;
    launchOk && cmdModeAllowed && ((newCmd == `FCS_CMD_ERASE_ALL)
                                   || (newCmd == `FCS_CMD_UNSECURE));
  endsequence

  sequence sVerifyEnd;
    (s_ff.st == FCS_VERIFY) && arrayDone;
  endsequence

  a_whole_idx_err: assert property (sLaunchWhole and (s_ff.idx != 3'h0)
    |=> flashStatus.accessError ##1 flashStatus.cmdComplete)
    else $error("whole erase with bad index not refused");

  a_whole_prot: assert property (sLaunchWhole and (s_ff.idx == 3'h0) and protAnyRegion
    |=> flashStatus.protViolation && !arrayReq.req)
    else $error("protected whole erase not refused");

  a_release_cause: assert property ($fell(secured) && $past(s_ff.cfgLoaded)
    |-> $past(s_ff.st) inside {FCS_VERIFY, FCS_KEY})
    else $error("security released without a passing command");

  a_busy_no_write: assert property (!flashStatus.cmdComplete && paramWrEn
    |=> $stable(params))
    else $error("parameter written while busy");

  a_verify_flags: assert property (sVerifyEnd
    |=> (flashStatus.verifyError == $past(verifyFail))
        && (flashStatus.uncorrectable == $past(verifyUncorrectable)))
    else $error("verify flags do not follow verify result");

  a_fail_keeps_sec: assert property (sVerifyEnd and verifyFail |=> $stable(secured))
    else $error("security changed after failed verify");

  a_fin_complete: assert property ((s_ff.st == FCS_FIN) |=> flashStatus.cmdComplete
    ##0 (s_ff.st == FCS_IDLE))
    else $error("completion flag not set at finish");

  a_key_locked: assert property (launchOk && cmdModeAllowed && s_ff.keyLock
    && (newCmd == `FCS_CMD_KEY_VERIFY) |=> flashStatus.accessError && !keyRdReq)
    else $error("key verify ran after a mismatch");

  a_reject_no_array: assert property ((s_ff.st == FCS_CHECK) && !blockValid
    |=> !arrayReq.req ##1 flashStatus.cmdComplete)
    else $error("invalid block reached the array");

endmodule

//--- include/fcs_cfg.svh
// Constants of the flash erase and security command sequencer.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// ==========================================================================
// Command codes
`define FCS_CMD_ERASE_ALL 8'h08
`define FCS_CMD_ERASE_BLK 8'h09
`define FCS_CMD_ERASE_SEC 8'h0A
`define FCS_CMD_UNSECURE 8'h0B
`define FCS_CMD_KEY_VERIFY 8'h0C

// ==========================================================================
// Parameter index values expected at launch
`define FCS_IDX_NONE 3'h0
`define FCS_IDX_ADDR 3'h1
`define FCS_IDX_KEYS 3'h4

// ==========================================================================
// Field positions in parameter word 0
`define FCS_CMD_HI 15
`define FCS_CMD_LO 8
`define FCS_BLK_HI 6

// ==========================================================================
// Key enable value, key location, reset values
`define FCS_BACKDOOR_KEY_ENABLE_ON 2'h2
`define FCS_KEY_BASE 23'h7FFF00
`define FCS_KEY_LAST 2'h3
`define FCS_RST_SECURED 1'b1
`define FCS_PARAM_WORDS 6

`endif

//--- include/fcs_pkg.sv
// Types of the flash erase and security command sequencer.
package fcs_pkg;

  typedef enum logic [2:0] {
    FCS_IDLE,
    FCS_CHECK,
    FCS_ERASE,
    FCS_VERIFY,
    FCS_KEY,
    FCS_FIN
  } fcs_state_e;

  typedef enum logic [1:0] {
    FCS_SCOPE_ALL,
    FCS_SCOPE_BLOCK,
    FCS_SCOPE_SECTOR
  } fcs_scope_e;

  typedef logic [5:0][15:0] fcs_words_t;

  // Request towards the flash array.
  typedef struct packed {
    logic req;
    logic verify;
    fcs_scope_e scope;
    logic [22:0] addr;
  } fcs_array_req_s;

  // Status flags seen by software.
  typedef struct packed {
    logic cmdComplete;
    logic accessError;
    logic protViolation;
    logic verifyError;
    logic uncorrectable;
  } fcs_flags_s;

  typedef struct packed {
    fcs_state_e st;
    logic [7:0] cmd;
    logic [2:0] idx;
    fcs_flags_s flags;
    logic secured;
    logic cfgLoaded;
    logic keyLock;
    fcs_array_req_s arr;
    logic keyReq;
    logic [1:0] keyIdx;
    logic [22:0] keyAddr;
  } fcs_state_s;

endpackage

//--- src/fcs_param_bank.sv
// Command parameter word bank written at the selected index.
`timescale 1ns/100ps
`include "fcs_cfg.svh"
module fcs_param_bank
  import fcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Write port
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [15:0] wrData,
  // Stored words
  output fcs_words_t words
);

  fcs_words_t words_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      words_ff <= '0;
    end else if (wrEn && (wrIdx < 3'(`FCS_PARAM_WORDS))) begin
      words_ff[wrIdx] <= wrData;
    end
  end

  assign words = words_ff;

endmodule

//--- dv/testbench.sv
// Self-checking bench for the erase, unsecure and key verify sequencer.
`timescale 1ns/100ps
module testbench import fcs_pkg::*;;
  typedef struct packed {
    logic [7:0] cmd; logic [2:0] idx; logic [6:0] blk; logic [15:0] lo;
    logic md, pa, bv, bd, tp, vf, vu; logic [3:0] ef; logic sec;
  } fcs_row_s;
  logic core_clk, reset, paramIdxWrEn, paramWrEn, cmdLaunch, errFlagClear;
  logic [2:0] paramIdxWrData, cmdParamIndex;
  logic [15:0] paramWrData, keyRdData;
  fcs_flags_s flashStatus;
  logic secCfgSecure, cmdModeAllowed, protAnyRegion, blockValid, blockIsData, targetProtected;
  logic [1:0] backdoorKeyEnable, lastScope;
  fcs_array_req_s arrayReq;
  logic arrayDone, verifyFail, verifyUncorrectable, keyRdReq, keyRdValid, secured, vF, vU;
  logic [22:0] keyRdAddr, lastAddr;
  logic [15:0] w [1:4];
  logic [15:0] storedKey [4] = '{16'h3C5A, 16'h0F1E, 16'hA596, 16'h7E81};
  int errCount, checks, reqCnt, keyCnt, i;
  fcs_row_s rows [19] = '{
    '{8'h08, 3'h1, 7'h00, 16'h0000, 1, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h08, 3'h0, 7'h00, 16'h0000, 1, 1, 1, 0, 0, 0, 0, 4'h4, 1},
    '{8'h09, 3'h0, 7'h7C, 16'h1238, 1, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h09, 3'h1, 7'h7C, 16'h1238, 1, 0, 0, 0, 0, 0, 0, 4'h8, 1},
    '{8'h09, 3'h1, 7'h7C, 16'h1233, 1, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h09, 3'h1, 7'h10, 16'h0001, 1, 0, 1, 1, 0, 0, 0, 4'h8, 1},
    '{8'h09, 3'h1, 7'h10, 16'h0002, 1, 0, 1, 1, 1, 0, 0, 4'h4, 1},
    '{8'h09, 3'h1, 7'h10, 16'h0002, 1, 0, 1, 1, 0, 1, 1, 4'h3, 1},
    '{8'h0A, 3'h1, 7'h7C, 16'h1234, 1, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h0A, 3'h1, 7'h7C, 16'h1238, 1, 0, 0, 0, 0, 0, 0, 4'h8, 1},
    '{8'h0A, 3'h1, 7'h7C, 16'h1238, 1, 0, 1, 0, 1, 0, 0, 4'h4, 1},
    '{8'h0A, 3'h1, 7'h10, 16'h1238, 1, 0, 1, 1, 0, 0, 0, 4'h8, 1},
    '{8'h0A, 3'h1, 7'h7C, 16'h1238, 1, 0, 1, 0, 0, 1, 0, 4'h2, 1},
    '{8'h0B, 3'h1, 7'h00, 16'h0000, 1, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h0B, 3'h0, 7'h00, 16'h0000, 1, 1, 1, 0, 0, 0, 0, 4'h4, 1},
    '{8'h0B, 3'h0, 7'h00, 16'h0000, 1, 0, 1, 0, 0, 1, 0, 4'h2, 1},
    '{8'h0C, 3'h0, 7'h00, 16'h0000, 1, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h09, 3'h1, 7'h7C, 16'h1238, 0, 0, 1, 0, 0, 0, 0, 4'h8, 1},
    '{8'h08, 3'h0, 7'h00, 16'h0000, 1, 0, 1, 0, 0, 0, 0, 4'h0, 0}
  };

  fcs_sequencer u_fcs_sequencer (.core_clk(core_clk), .reset(reset),
    .paramIdxWrEn(paramIdxWrEn), .paramIdxWrData(paramIdxWrData), .paramWrEn(paramWrEn),
    .paramWrData(paramWrData), .cmdLaunch(cmdLaunch), .errFlagClear(errFlagClear),
    .cmdParamIndex(cmdParamIndex), .flashStatus(flashStatus), .secCfgSecure(secCfgSecure),
    .backdoorKeyEnable(backdoorKeyEnable), .cmdModeAllowed(cmdModeAllowed),
    .protAnyRegion(protAnyRegion), .blockValid(blockValid), .blockIsData(blockIsData),
    .targetProtected(targetProtected), .arrayReq(arrayReq), .arrayDone(arrayDone),
    .verifyFail(verifyFail), .verifyUncorrectable(verifyUncorrectable),
    .keyRdReq(keyRdReq), .keyRdAddr(keyRdAddr), .keyRdValid(keyRdValid),
    .keyRdData(keyRdData), .secured(secured));

  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end

  task chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task chkFlags(input fcs_flags_s got, input fcs_flags_s exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t flags got %b exp %b", $time, got, exp);
    end
  endtask

  // The array answers every request a few cycles later; a request that
  // stands in the cycle of the answer's end is taken without a gap.
  always begin
    @(negedge core_clk);
    while (arrayReq.req === 1'b1) begin
      reqCnt++;
      lastScope = arrayReq.scope;
      lastAddr = arrayReq.addr;
      repeat (2) @(negedge core_clk);
      arrayDone = 1;
      verifyFail = vF;
      verifyUncorrectable = vU;
      @(negedge core_clk);
      arrayDone = 0;
      verifyFail = 0;
      verifyUncorrectable = 0;
    end
  end

  // Stored key reads answer one cycle late; data is scrambled outside the answer.
  always begin
    @(negedge core_clk);
    while (keyRdReq === 1'b1) begin
      chkVal(32'(keyRdAddr), 32'(23'h7FFF00 + 23'(keyCnt * 2)), "key addr");
      @(negedge core_clk);
      keyRdValid = 1;
      keyRdData = storedKey[keyCnt[1:0]];
      keyCnt++;
      @(negedge core_clk);
      keyRdValid = 0;
      keyRdData = ~keyRdData;
    end
  end

  task wr(input logic [2:0] idx, input logic [15:0] d);
    paramIdxWrEn = 1;
    paramIdxWrData = idx;
    @(negedge core_clk);
    paramIdxWrEn = 0;
    paramWrEn = 1;
    paramWrData = d;
    @(negedge core_clk);
    paramWrEn = 0;
  endtask

  task launch(input logic [7:0] cmd, input logic [6:0] blk, input int nw, input logic [2:0] idx);
    reqCnt = 0;
    keyCnt = 0;
    wr(3'h0, {cmd, 1'b0, blk});
    for (int k = 1; k <= nw; k++) wr(3'(k), w[k]);
    paramIdxWrEn = 1;
    paramIdxWrData = idx;
    @(negedge core_clk);
    paramIdxWrEn = 0;
    cmdLaunch = 1;
    @(negedge core_clk);
    cmdLaunch = 0;
    chkVal(32'(flashStatus.cmdComplete), 0, "busy");
    paramWrEn = 1;
    paramWrData = 16'hFFFF;
    @(negedge core_clk);
    paramWrEn = 0;
    for (int t = 0; t < 100 && flashStatus.cmdComplete !== 1'b1; t++) @(negedge core_clk);
  endtask

  task clearErr();
    errFlagClear = 1;
    @(negedge core_clk);
    errFlagClear = 0;
  endtask

  task resetDut();
    reset = 1;
    repeat (6) @(negedge core_clk);
    reset = 0;
    repeat (2) @(negedge core_clk);
  endtask

  task keyRun(input logic [1:0] en, input logic [15:0] bad, input logic [3:0] ef, input logic s);
    backdoorKeyEnable = en;
    for (int k = 1; k <= 4; k++) w[k] = storedKey[k - 1];
    w[3] = w[3] ^ bad;
    launch(8'h0C, 7'h00, 4, 3'h4);
    chkFlags(flashStatus, {1'b1, ef});
    chkVal(32'(secured), 32'(s), "secured");
    clearErr();
    $display("key test done");
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {reset, paramIdxWrEn, paramWrEn, cmdLaunch, errFlagClear, arrayDone} = 6'h20;
    {verifyFail, verifyUncorrectable, keyRdValid, vF, vU, protAnyRegion} = 6'h00;
    {paramIdxWrData, paramWrData, keyRdData, backdoorKeyEnable} = '0;
    {secCfgSecure, cmdModeAllowed, blockValid, blockIsData, targetProtected} = 5'h1C;
    {errCount, checks, reqCnt, keyCnt} = '0;
    resetDut();
    chkFlags(flashStatus, 5'h10);
    chkVal(32'(secured), 1, "reset secured");
    for (i = 0; i < 19; i++) begin
      {cmdModeAllowed, protAnyRegion, blockValid, blockIsData, targetProtected} = rows[i][11:7];
      {vF, vU} = {rows[i].vf, rows[i].vu};
      w[1] = rows[i].lo;
      launch(rows[i].cmd, rows[i].blk, 1, rows[i].idx);
      chkFlags(flashStatus, {1'b1, rows[i].ef});
      chkVal(32'(secured), 32'(rows[i].sec), "secured");
      chkVal(reqCnt, (rows[i].ef[3:2] != 0) ? 0 : 2, "array requests");
      if (rows[i].ef[3:2] == 0) begin
        chkVal(32'(lastScope), (rows[i].cmd == 8'h09) ? 1 : (rows[i].cmd == 8'h0A) ? 2 : 0,
               "scope");
        if (rows[i].cmd inside {8'h09, 8'h0A})
          chkVal(32'(lastAddr), 32'({rows[i].blk, rows[i].lo}), "addr");
      end
      clearErr();
      $display("row %0d done", i);
    end
    {vF, vU} = 2'b00;
    resetDut();
    keyRun(2'h2, 16'h0040, 4'h8, 1);
    keyRun(2'h2, 16'h0000, 4'h8, 1);
    resetDut();
    keyRun(2'h1, 16'h0000, 4'h8, 1);
    keyRun(2'h2, 16'h0000, 4'h0, 0);
    chkVal(keyCnt, 4, "key reads");
    print_verdict();
  end

  initial begin
    #150000;
    errCount++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
